//--- design/ssp_pkg.sv
// constants of the system stack pointer unit
// assumes a 16-bit register port and a cpu-side stack operation port
//
// Contract
// RULE1: decrement before push, increment after pop
// RULE2: pointer bit0 zero, bits 15..11 one
// RULE3: pointer resets to FC00h
// RULE4: software avoids pop right after pointer write
// RULE5: depth select picks 256/128/64/32 words
// RULE6: physical stack top fixed at FBFEh
// RULE7: physical = FBFEh minus inverted pointer masked
// RULE8: virtual portions wrap onto one physical area
// RULE9: reset pointer maps onto identical physical addresses
// RULE10: overflow trap when pointer below limit after decrease
// RULE11: overflow limit bit0 zero, bits 15..11 one
// RULE12: overflow limit resets to FA00h
// RULE13: overflow limit at address FE14h, short 0Ah
// RULE14: trap entry pushes three words
// RULE15: software sets limit to lowest top plus 12
// RULE16: underflow trap when pointer above limit after increase
// RULE17: underflow limit resets to FC00h, same masking
// RULE18: trap requests are one-cycle, cycle after change
package ssp_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [15:0] OVF_LIMIT_ADDR   = 16'hFE14;
    localparam logic [7:0]  OVF_LIMIT_SHORT  = 8'h0A;
    localparam logic [15:0] UNF_LIMIT_ADDR   = 16'hFE16;
    localparam logic [15:0] STACK_PTR_ADDR   = 16'hFE12;
    localparam logic [15:0] SYS_CONFIG_ADDR  = 16'hFF12;
    localparam logic [15:0] IRQ_STATUS_ADDR  = 16'hFE30;
    localparam logic [15:0] IRQ_MASK_ADDR    = 16'hFE32;
    // ------------------------------------------------------------
    // reset values and fields
    // ------------------------------------------------------------
    localparam logic [15:0] STACK_PTR_RESET  = 16'hFC00;
    localparam logic [15:0] OVF_LIMIT_RESET  = 16'hFA00;
    localparam logic [15:0] UNF_LIMIT_RESET  = 16'hFC00;
    localparam logic [15:0] PTR_FORCE_ONE    = 16'hF800;
    localparam logic [15:0] PTR_KEEP_MASK    = 16'h07FE;
    localparam logic [15:0] PHYS_TOP         = 16'hFBFE;
    localparam logic [15:0] WORD_STEP        = 16'h0002;
    localparam int          DEPTH_LSB        = 13;
    localparam logic [1:0]  DEPTH_RESET      = 2'h0;
    localparam logic [15:0] MASK_256         = 16'h01FE;
    localparam logic [15:0] MASK_128         = 16'h00FE;
    localparam logic [15:0] MASK_64          = 16'h007E;
    localparam logic [15:0] MASK_32          = 16'h003E;
    localparam logic [1:0]  ENTRY_WORDS      = 2'h3;
    localparam int          IRQ_OVF_BIT      = 0;
    localparam int          IRQ_UNF_BIT      = 1;
    // ------------------------------------------------------------
    // stack operations from the cpu
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SSP_OP_NONE  = 3'h0,
        SSP_OP_PUSH  = 3'h1,
        SSP_OP_POP   = 3'h2,
        SSP_OP_SUB   = 3'h3,
        SSP_OP_ADD   = 3'h4,
        SSP_OP_ENTRY = 3'h5
    } ssp_op_t;
    typedef enum logic [1:0] {
        SSP_ST_IDLE = 2'b00,
        SSP_ST_W1   = 2'b01,
        SSP_ST_W2   = 2'b11,
        SSP_ST_W3   = 2'b10
    } ssp_state_t;
endpackage : ssp_pkg

//--- design/ssp_top.sv
// system stack pointer unit: pointer, limits, physical mapping, traps
// assumes a single-cycle register port and one stack op per cycle
`timescale 1ns/1ps
module ssp_top (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [15:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic [2:0]  stack_op,
    input  wire logic [15:0] stack_op_amount,
    output logic      [15:0] phys_addr,
    output logic             phys_wr,
    output logic             phys_rd,
    output logic      [1:0]  entry_word_idx,
    output logic             entry_busy,
    output logic      [15:0] top_of_stack,
    output logic             ovf_trap_req,
    output logic             unf_trap_req,
    output logic             irq
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [15:0]        sp_reg, sp_next;
    logic [15:0]        ovf_reg;
    logic [15:0]        unf_reg;
    logic [1:0]         depth_reg;
    logic [1:0]         irq_stat_reg, irq_stat_next, irq_mask_reg;
    ssp_pkg::ssp_state_t st_reg;
    logic               dec_evt, inc_evt, push_now, pop_now;
    logic               chk_ovf_reg, chk_unf_reg;
    logic [15:0]        size_mask, phys_next;
    ssp_pkg::ssp_op_t   op;

    assign op = ssp_pkg::ssp_op_t'(stack_op);

    function automatic logic [15:0] fix_ptr(input logic [15:0] v);
        fix_ptr = (v & ssp_pkg::PTR_KEEP_MASK) | ssp_pkg::PTR_FORCE_ONE;
    endfunction : fix_ptr

    // ------------------------------------------------------------
    // operation decode
    // ------------------------------------------------------------
    always_comb begin
        push_now = 1'b0;
        pop_now  = 1'b0;
        dec_evt  = 1'b0;
        inc_evt  = 1'b0;
        sp_next  = sp_reg;
        if (st_reg != ssp_pkg::SSP_ST_IDLE) begin
            push_now = 1'b1;
            dec_evt  = 1'b1;
            sp_next  = fix_ptr(sp_reg - ssp_pkg::WORD_STEP); // RULE1 RULE14
        end else begin
            // entry only starts the sequence; its three pushes follow
            case (op)
                ssp_pkg::SSP_OP_PUSH: begin
                    push_now = 1'b1;
                    dec_evt  = 1'b1;
                    sp_next  = fix_ptr(sp_reg - ssp_pkg::WORD_STEP); // RULE1
                end
                ssp_pkg::SSP_OP_POP: begin
                    pop_now = 1'b1;
                    inc_evt = 1'b1;
                    sp_next = fix_ptr(sp_reg + ssp_pkg::WORD_STEP); // RULE1
                end
                ssp_pkg::SSP_OP_SUB: begin
                    dec_evt = 1'b1;
                    sp_next = fix_ptr(sp_reg - stack_op_amount);
                end
                ssp_pkg::SSP_OP_ADD: begin
                    inc_evt = 1'b1;
                    sp_next = fix_ptr(sp_reg + stack_op_amount);
                end
                default: begin
                    sp_next = sp_reg;
                end
            endcase
        end
        // a pointer write from the register port beats any stack op
        if (reg_wr && reg_addr == ssp_pkg::STACK_PTR_ADDR) begin
            push_now = 1'b0;
            pop_now  = 1'b0;
            dec_evt  = 1'b0;
            inc_evt  = 1'b0;
            sp_next  = fix_ptr(reg_wdata); // RULE2
        end
    end

    // ------------------------------------------------------------
    // stack pointer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sp_reg <= ssp_pkg::STACK_PTR_RESET; // RULE3
        end else begin
            sp_reg <= sp_next; // RULE2
        end
    end

    // ------------------------------------------------------------
    // entry sequence: three pushes
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= ssp_pkg::SSP_ST_IDLE;
        end else begin
            case (st_reg)
                ssp_pkg::SSP_ST_IDLE: begin
                    if (op == ssp_pkg::SSP_OP_ENTRY) begin
                        st_reg <= ssp_pkg::SSP_ST_W1; // RULE14
                    end
                end
                ssp_pkg::SSP_ST_W1: begin
                    st_reg <= ssp_pkg::SSP_ST_W2;
                end
                ssp_pkg::SSP_ST_W2: begin
                    st_reg <= ssp_pkg::SSP_ST_W3;
                end
                default: begin
                    st_reg <= ssp_pkg::SSP_ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // physical mapping
    // ------------------------------------------------------------
    always_comb begin
        case (depth_reg) // RULE5
            2'h0:    size_mask = ssp_pkg::MASK_256;
            2'h1:    size_mask = ssp_pkg::MASK_128;
            2'h2:    size_mask = ssp_pkg::MASK_64;
            default: size_mask = ssp_pkg::MASK_32;
        endcase
        // pushes write at the decremented pointer, pops read at the current one
        if (push_now) begin
            phys_next = ssp_pkg::PHYS_TOP - (~sp_next & size_mask); // RULE6 RULE7 RULE8 RULE9
        end else begin
            phys_next = ssp_pkg::PHYS_TOP - (~sp_reg & size_mask); // RULE7
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phys_addr      <= ssp_pkg::PHYS_TOP;
            phys_wr        <= 1'b0;
            phys_rd        <= 1'b0;
            entry_word_idx <= 2'h0;
            entry_busy     <= 1'b0;
            top_of_stack   <= ssp_pkg::STACK_PTR_RESET;
        end else begin
            phys_addr    <= phys_next;
            phys_wr      <= push_now;
            phys_rd      <= pop_now;
            entry_busy   <= st_reg != ssp_pkg::SSP_ST_IDLE;
            top_of_stack <= sp_next;
            case (st_reg)
                ssp_pkg::SSP_ST_W1: entry_word_idx <= 2'h1;
                ssp_pkg::SSP_ST_W2: entry_word_idx <= 2'h2;
                ssp_pkg::SSP_ST_W3: entry_word_idx <= ssp_pkg::ENTRY_WORDS;
                default:            entry_word_idx <= 2'h0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // limit and config registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ovf_reg   <= ssp_pkg::OVF_LIMIT_RESET; // RULE12
            unf_reg   <= ssp_pkg::UNF_LIMIT_RESET; // RULE17
            depth_reg <= ssp_pkg::DEPTH_RESET;
        end else if (reg_wr) begin
            if (reg_addr == ssp_pkg::OVF_LIMIT_ADDR) begin // RULE13
                ovf_reg <= fix_ptr(reg_wdata); // RULE11
            end
            if (reg_addr == ssp_pkg::UNF_LIMIT_ADDR) begin
                unf_reg <= fix_ptr(reg_wdata); // RULE17
            end
            if (reg_addr == ssp_pkg::SYS_CONFIG_ADDR) begin
                depth_reg <= reg_wdata[ssp_pkg::DEPTH_LSB +: 2];
            end
        end
    end

    // ------------------------------------------------------------
    // bound checks, one cycle after the change
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            chk_ovf_reg  <= 1'b0;
            chk_unf_reg  <= 1'b0;
            ovf_trap_req <= 1'b0;
            unf_trap_req <= 1'b0;
        end else begin
            chk_ovf_reg  <= dec_evt;
            chk_unf_reg  <= inc_evt;
            ovf_trap_req <= dec_evt && (sp_next < ovf_reg); // RULE10 RULE18
            unf_trap_req <= inc_evt && (sp_next > unf_reg); // RULE16 RULE18
        end
    end

    // ------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------
    always_comb begin
        irq_stat_next = irq_stat_reg;
        if (reg_wr && reg_addr == ssp_pkg::IRQ_STATUS_ADDR) begin
            irq_stat_next = irq_stat_reg & ~reg_wdata[1:0];
        end
        // set wins over clear
        irq_stat_next[ssp_pkg::IRQ_OVF_BIT] |= ovf_trap_req;
        irq_stat_next[ssp_pkg::IRQ_UNF_BIT] |= unf_trap_req;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat_reg <= 2'h0;
            irq_mask_reg <= 2'h0;
            irq          <= 1'b0;
        end else begin
            irq_stat_reg <= irq_stat_next;
            if (reg_wr && reg_addr == ssp_pkg::IRQ_MASK_ADDR) begin
                irq_mask_reg <= reg_wdata[1:0];
            end
            irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                ssp_pkg::STACK_PTR_ADDR:  reg_rdata <= sp_reg;
                ssp_pkg::OVF_LIMIT_ADDR:  reg_rdata <= ovf_reg;
                ssp_pkg::UNF_LIMIT_ADDR:  reg_rdata <= unf_reg;
                ssp_pkg::SYS_CONFIG_ADDR: reg_rdata <= {1'b0, depth_reg, 13'h0000};
                ssp_pkg::IRQ_STATUS_ADDR: reg_rdata <= {14'h0000, irq_stat_reg};
                ssp_pkg::IRQ_MASK_ADDR:   reg_rdata <= {14'h0000, irq_mask_reg};
                default:                  reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // tied bits of pointer and limits
    a_ptr_forced: assert property (@(posedge clk) disable iff (!arst_n) // RULE2
        (sp_reg & 16'hF801) == 16'hF800) else $error("pointer fixed bits wrong");
    a_ovf_forced: assert property (@(posedge clk) disable iff (!arst_n) // RULE11
        (ovf_reg & 16'hF801) == 16'hF800) else $error("ovf limit fixed bits wrong");
    a_unf_forced: assert property (@(posedge clk) disable iff (!arst_n) // RULE17
        (unf_reg & 16'hF801) == 16'hF800) else $error("unf limit fixed bits wrong");
    a_tos_forced: assert property (@(posedge clk) disable iff (!arst_n) // RULE2
        (top_of_stack & 16'hF801) == 16'hF800) else $error("top of stack fixed bits wrong");

    // register writes
    a_ptr_write: assert property (@(posedge clk) disable iff (!arst_n) // RULE2
        (reg_wr && reg_addr == ssp_pkg::STACK_PTR_ADDR)
        |=> sp_reg == fix_ptr($past(reg_wdata))) else $error("pointer write lost");
    a_ovf_write: assert property (@(posedge clk) disable iff (!arst_n) // RULE11
        (reg_wr && reg_addr == ssp_pkg::OVF_LIMIT_ADDR)
        |=> ovf_reg == fix_ptr($past(reg_wdata))) else $error("ovf limit write lost");
    a_unf_write: assert property (@(posedge clk) disable iff (!arst_n) // RULE17
        (reg_wr && reg_addr == ssp_pkg::UNF_LIMIT_ADDR)
        |=> unf_reg == fix_ptr($past(reg_wdata))) else $error("unf limit write lost");
    a_depth_write: assert property (@(posedge clk) disable iff (!arst_n) // RULE5
        (reg_wr && reg_addr == ssp_pkg::SYS_CONFIG_ADDR)
        |=> depth_reg == $past(reg_wdata[14:13])) else $error("depth write lost");

    // pointer steps
    a_push_dec: assert property (@(posedge clk) disable iff (!arst_n) // RULE1
        (op == ssp_pkg::SSP_OP_PUSH && st_reg == ssp_pkg::SSP_ST_IDLE && !reg_wr)
        |=> sp_reg == fix_ptr($past(sp_reg) - 16'h0002)) else $error("push no dec");
    a_pop_inc: assert property (@(posedge clk) disable iff (!arst_n) // RULE1
        (op == ssp_pkg::SSP_OP_POP && st_reg == ssp_pkg::SSP_ST_IDLE && !reg_wr)
        |=> sp_reg == fix_ptr($past(sp_reg) + 16'h0002)) else $error("pop no inc");
    a_pop_strobe: assert property (@(posedge clk) disable iff (!arst_n) // RULE1
        (op == ssp_pkg::SSP_OP_POP && st_reg == ssp_pkg::SSP_ST_IDLE && !reg_wr)
        |=> phys_rd && top_of_stack == sp_reg) else $error("pop strobe or copy wrong");

    // physical mapping and entry sequence
    a_phys_range: assert property (@(posedge clk) disable iff (!arst_n) // RULE6
        phys_wr |-> (phys_addr <= 16'hFBFE && phys_addr >= 16'hFA00))
        else $error("physical address out of stack");
    a_phys_even: assert property (@(posedge clk) disable iff (!arst_n) // RULE7
        (phys_wr || phys_rd) |-> !phys_addr[0]) else $error("physical address odd");
    a_entry_three: assert property (@(posedge clk) disable iff (!arst_n) // RULE14
        (op == ssp_pkg::SSP_OP_ENTRY && st_reg == ssp_pkg::SSP_ST_IDLE)
        |=> !phys_wr ##1 phys_wr [*3]) else $error("entry not three write cycles");
    a_entry_idx: assert property (@(posedge clk) disable iff (!arst_n) // RULE14
        (op == ssp_pkg::SSP_OP_ENTRY && st_reg == ssp_pkg::SSP_ST_IDLE)
        |=> ##1 entry_word_idx == 2'h1 ##1 entry_word_idx == 2'h2 ##1 entry_word_idx == 2'h3)
        else $error("entry word order wrong");
    a_entry_busy: assert property (@(posedge clk) disable iff (!arst_n) // RULE14
        (entry_word_idx != 2'h0) |-> entry_busy) else $error("entry word without busy");

    // trap requests
    a_ovf_trap: assert property (@(posedge clk) disable iff (!arst_n) // RULE10
        ovf_trap_req |-> chk_ovf_reg && top_of_stack < ovf_reg)
        else $error("ovf trap without cause");
    a_unf_trap: assert property (@(posedge clk) disable iff (!arst_n) // RULE16
        unf_trap_req |-> chk_unf_reg && top_of_stack > unf_reg)
        else $error("unf trap without cause");
    a_ovf_pulse: assert property (@(posedge clk) disable iff (!arst_n) // RULE18
        (dec_evt && sp_next < ovf_reg) |=> ovf_trap_req) else $error("ovf trap late");
    a_unf_pulse: assert property (@(posedge clk) disable iff (!arst_n) // RULE18
        (inc_evt && sp_next > unf_reg) |=> unf_trap_req) else $error("unf trap late");
    a_trap_excl: assert property (@(posedge clk) disable iff (!arst_n) // RULE18
        !(ovf_trap_req && unf_trap_req)) else $error("both traps at once");

    // interrupt status and read port
    a_stat_sticky: assert property (@(posedge clk) disable iff (!arst_n)
        irq_stat_reg[ssp_pkg::IRQ_OVF_BIT] && !(reg_wr && reg_addr == ssp_pkg::IRQ_STATUS_ADDR)
        |=> irq_stat_reg[ssp_pkg::IRQ_OVF_BIT]) else $error("ovf status lost");
    a_stat_set: assert property (@(posedge clk) disable iff (!arst_n)
        ovf_trap_req |=> irq_stat_reg[ssp_pkg::IRQ_OVF_BIT]) else $error("ovf status not set");
    a_unf_set: assert property (@(posedge clk) disable iff (!arst_n)
        unf_trap_req |=> irq_stat_reg[ssp_pkg::IRQ_UNF_BIT]) else $error("unf status not set");
    a_irq_level: assert property (@(posedge clk) disable iff (!arst_n)
        (|(irq_stat_reg & irq_mask_reg)) |=> irq) else $error("irq missing");
    a_rdata_idle: assert property (@(posedge clk) disable iff (!arst_n)
        !reg_rd |=> reg_rdata == 16'h0000) else $error("read data outside its cycle");

    // ------------------------------------------------------------
    // main scenarios
    // ------------------------------------------------------------
    c_push: cover property (@(posedge clk) disable iff (!arst_n) phys_wr);
    c_ovf: cover property (@(posedge clk) disable iff (!arst_n) ovf_trap_req);
    c_unf: cover property (@(posedge clk) disable iff (!arst_n) unf_trap_req);
    c_entry: cover property (@(posedge clk) disable iff (!arst_n)
        st_reg == ssp_pkg::SSP_ST_W3);
    c_wrap: cover property (@(posedge clk) disable iff (!arst_n)
        phys_wr && phys_addr == ssp_pkg::PHYS_TOP && top_of_stack != ssp_pkg::PHYS_TOP);
endmodule : ssp_top

//--- tb/ssp_ram_model.sv
// stack ram beside the pointer unit: counts pushed words, keeps the address of the last push or pop
// assumes registered single-cycle strobes from the unit
`timescale 1ns/1ps
module ssp_ram_model (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [15:0] phys_addr,
    input  wire logic        phys_wr,
    input  wire logic        phys_rd,
    output logic      [7:0]  wr_count,
    output logic      [15:0] last_addr
);
    // ------------------------------------------------------------
    // access log
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_count  <= 8'h00;
            last_addr <= 16'h0000;
        end else if (phys_wr || phys_rd) begin
            wr_count  <= wr_count + {7'h00, phys_wr};
            last_addr <= phys_addr;
        end
    end
endmodule : ssp_ram_model

//--- tb/system_stack_pointer_unit_test.sv
// self-checking bench of the stack pointer unit
// assumes registered outputs one cycle after each request
`timescale 1ns/1ps
module system_stack_pointer_unit_test;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_rdata, phys_addr, top_of_stack, last_addr;
    logic [2:0]  stack_op = 3'h0;
    logic [15:0] stack_op_amount = 16'h0000;
    logic        phys_wr, phys_rd, entry_busy, ovf_trap_req, unf_trap_req, irq;
    logic [1:0]  entry_word_idx;
    logic [7:0]  wr_count, wc0;
    int          n_mismatch = 0;
    int          check_count = 0;
    int          cyc = 0;
    always #2.5 clk = ~clk;
    ssp_top u_ssp_top (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .stack_op(stack_op), .stack_op_amount(stack_op_amount), .phys_addr(phys_addr),
        .phys_wr(phys_wr), .phys_rd(phys_rd), .entry_word_idx(entry_word_idx),
        .entry_busy(entry_busy), .top_of_stack(top_of_stack),
        .ovf_trap_req(ovf_trap_req), .unf_trap_req(unf_trap_req), .irq(irq));
    ssp_ram_model u_ssp_ram_model (.clk(clk), .arst_n(arst_n), .phys_addr(phys_addr),
        .phys_wr(phys_wr), .phys_rd(phys_rd), .wr_count(wr_count), .last_addr(last_addr));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [15:0] phys(input logic [15:0] sp, input logic [1:0] d);
        logic [15:0] m;
        m = (d == 2'h0) ? 16'h01FE : (d == 2'h1) ? 16'h00FE : (d == 2'h2) ? 16'h007E : 16'h003E;
        return 16'hFBFE - (~sp & m);
    endfunction : phys
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd
    task automatic op(input logic [2:0] c, input logic [15:0] a);
        @(posedge clk);
        stack_op <= c;
        stack_op_amount <= a;
        @(posedge clk);
        stack_op <= 3'h0;
        #1;
    endtask : op
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_and_masks;
        rd(16'hFE12, 16'hFC00);
        rd(16'hFE14, 16'hFA00);
        rd(16'hFE16, 16'hFC00);
        rd(16'hFE10, 16'h0000);
        wr(16'hFE12, 16'hFFFF);
        rd(16'hFE12, 16'hFFFE);
        wr(16'hFE12, 16'h0001);
        rd(16'hFE12, 16'hF800);
        wr(16'hFE14, 16'h0401);
        rd(16'hFE14, 16'hFC00);
        wr(16'hFE14, 16'hFFFF);
        rd(16'hFE14, 16'hFFFE);
        wr(16'hFE14, 16'hF800);
        wr(16'hFE12, 16'hFC00);
        op(3'h1, 16'h0000);
        chk(phys_addr, 16'hFBFE);
    endtask : t_reset_and_masks
    task automatic t_depths;
        for (int d = 0; d < 4; d++) begin
            wr(16'hFF12, {1'b0, d[1:0], 13'h0000});
            wr(16'hFE12, 16'hF9C4);
            op(3'h1, 16'h0000);
            chk({15'h0000, phys_wr}, 16'h0001);
            chk(phys_addr, phys(16'hF9C2, d[1:0]));
            chk(top_of_stack, 16'hF9C2);
        end
        wr(16'hFF12, 16'h4000);
        rd(16'hFF12, 16'h4000);
        wr(16'hFE12, 16'hFC82);
        op(3'h1, 16'h0000);
        chk(phys_addr, 16'hFB80);
        op(3'h1, 16'h0000);
        chk(phys_addr, 16'hFBFE);
        chk(top_of_stack, 16'hFC7E);
        @(posedge clk);
        op(3'h2, 16'h0000);
        chk({15'h0000, phys_rd}, 16'h0001);
        chk(phys_addr, 16'hFBFE);
        chk(top_of_stack, 16'hFC80);
    endtask : t_depths
    task automatic t_traps;
        wr(16'hFE30, 16'h0003);
        wr(16'hFF12, 16'h0000);
        wr(16'hFE14, 16'hFA0C);
        wr(16'hFE32, 16'h0000);
        wr(16'hFE12, 16'hFA0E);
        op(3'h3, 16'h0002);
        chk({15'h0000, ovf_trap_req}, 16'h0000);
        op(3'h3, 16'h0004);
        chk({15'h0000, ovf_trap_req}, 16'h0001);
        @(posedge clk);
        #1 chk({15'h0000, ovf_trap_req}, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
        rd(16'hFE30, 16'h0001);
        wr(16'hFE32, 16'h0001);
        rd(16'hFE32, 16'h0001);
        repeat (2) @(posedge clk);
        #1 chk({15'h0000, irq}, 16'h0001);
        wr(16'hFE30, 16'h0001);
        repeat (2) @(posedge clk);
        #1 chk({15'h0000, irq}, 16'h0000);
        wr(16'hFE12, 16'hFBFE);
        @(posedge clk);
        op(3'h2, 16'h0000);
        chk({15'h0000, unf_trap_req}, 16'h0000);
        op(3'h4, 16'h0002);
        chk({15'h0000, unf_trap_req}, 16'h0001);
        @(posedge clk);
        #1 chk({15'h0000, unf_trap_req}, 16'h0000);
    endtask : t_traps
    task automatic t_entry;
        wr(16'hFE12, 16'hFB00);
        wc0 = wr_count;
        op(3'h5, 16'h0000);
        chk({15'h0000, phys_wr}, 16'h0000);
        @(posedge clk);
        for (int i = 1; i < 4; i++) begin
            #1 chk({15'h0000, phys_wr}, 16'h0001);
            chk({14'h0000, entry_word_idx}, i[15:0]);
            chk({15'h0000, entry_busy}, 16'h0001);
            chk(phys_addr, phys(16'hFB00 - 16'(2 * i), 2'h0));
            @(posedge clk);
        end
        #1 chk({15'h0000, phys_wr}, 16'h0000);
        chk({15'h0000, entry_busy}, 16'h0000);
        chk({8'h00, wr_count - wc0}, 16'h0003);
        chk(last_addr, phys(16'hFAFA, 2'h0));
        rd(16'hFE12, 16'hFAFA);
    endtask : t_entry
    // ------------------------------------------------------------
    // sequence and timeout
    // ------------------------------------------------------------
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            stop_test();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        t_reset_and_masks();
        t_depths();
        t_traps();
        t_entry();
        stop_test();
    end
endmodule : system_stack_pointer_unit_test
